// *** pkg/aise_pkg.sv ***
// constants for the auxiliary interrupt status / enable register pair
// assumes a 32-bit apb slave port with byte addresses on 8 bits
package aise_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned ALIAS_W = 15;
    localparam int unsigned STATE_W = 3;
    localparam int unsigned STRB_W  = 4;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] PRI_STAT_ADDR = 8'h10;
    localparam logic [7:0] PRI_EN_ADDR   = 8'h14;
    localparam logic [7:0] AUX_STAT_ADDR = 8'h80;
    localparam logic [7:0] AUX_EN_ADDR   = 8'h84;

    // ----------------------------------------------------------------
    // field positions; flag bits are shared by the status and enable words
    // ----------------------------------------------------------------
    localparam int unsigned TX_EARLY_BIT = 31;
    localparam int unsigned RX_EARLY_BIT = 30;
    localparam int unsigned XCVR_BIT     = 29;
    localparam int unsigned TX_DEFER_BIT = 28;
    localparam int unsigned PAUSE_BIT    = 26;
    localparam int unsigned BUS_ERR_LSB  = 23;
    localparam int unsigned TX_STATE_LSB = 20;
    localparam int unsigned RX_STATE_LSB = 17;
    localparam int unsigned ADD_NORM_BIT = 16;
    localparam int unsigned ADD_ABN_BIT  = 15;
    localparam int unsigned PRI_NORM_BIT = 16;
    localparam int unsigned PRI_ABN_BIT  = 15;

    // ----------------------------------------------------------------
    // masks and reset values
    // ----------------------------------------------------------------
    // storage bits of the latched flags and of the enables
    localparam logic [31:0] FLAG_MASK     = 32'hF401_FFFF;
    localparam logic [31:0] EN_MASK       = 32'hF401_FFFF;
    // added normal sources (tx early, rx early)
    localparam logic [31:0] ADD_NORM_MASK = 32'hC000_0000;
    // added abnormal sources (transceiver, tx deferred, pause)
    localparam logic [31:0] ADD_ABN_MASK  = 32'h3400_0000;
    // which primary events count as normal; the rest are abnormal
    localparam logic [14:0] PRI_NORM_SRC  = 15'h0045;
    localparam logic [31:0] AUX_STAT_RST  = 32'h2000_8000;
    localparam logic [31:0] AUX_EN_RST    = 32'h0000_0000;

endpackage : aise_pkg

// *** pkg/aise_flag_if.sv ***
// carrier between the register front end and the latched flag bank
// assumes both ends sit on the same clock
interface aise_flag_if;
    logic [31:0] set;   // one-cycle set requests per bit
    logic [31:0] clr;   // one-cycle write-one-clear requests per bit
    logic [31:0] flags; // latched flags

    modport bank (input set, input clr, output flags);
    modport user (output set, output clr, input flags);
endinterface : aise_flag_if

// *** logic/aise_flag_bank.sv ***
// latched high flags, cleared by a one written to the bit
// assumes set and clr come from logic on pclk
module aise_flag_bank
    import aise_pkg::*;
(
    input  wire logic pclk,    // bus clock
    input  wire logic presetn, // async reset, active low
    aise_flag_if.bank fl       // set / clear requests and flags
);

    // ----------------------------------------------------------------
    // one flop per storage bit, constant zero elsewhere
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_bit
            if (FLAG_MASK[i]) begin : g_store
                logic flag;
                logic next_flag;
                // set beats a clear in the same cycle, so no event is lost
                always_comb begin
                    next_flag = (flag & ~fl.clr[i]) | fl.set[i];
                end
                // reset value per bit; some flags start high
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        flag <= AUX_STAT_RST[i];
                    end else begin
                        flag <= next_flag;
                    end
                end
                assign fl.flags[i] = flag;
            end else begin : g_none
                assign fl.flags[i] = 1'b0;
            end
        end
    endgenerate

endmodule : aise_flag_bank

// *** logic/aise_top.sv ***
// auxiliary interrupt status and enable registers behind an apb slave
// assumes event inputs and engine states come from logic on pclk
//
// Function
// - read-only three-bit transmit engine state field
// - read-only three-bit receive engine state field
// - added-normal summary at bit 16, latched, resets 0
// - added-abnormal summary at bit 15, latched, resets 1
// - low 15 status bits alias primary status
// - latched flags clear only on written one
// - tx early enable, bit 31, resets 0
// - rx early enable, bit 30, resets 0
// - transceiver enable, bit 29, resets 0
// - tx deferred enable, bit 28, resets 0
// - pause enable bit 26; 27, 25..17 reserved
// - tx early flag set when enabled and moved
// - rx early flag set when enabled and filled
// - added-normal enable folds early into normal summary
// - added-abnormal enable folds added abnormal into summary
//
// The implementer's own choice: the APB interface to the registers.
module aise_top
    import aise_pkg::*;
(
    input  wire logic               pclk,                     // bus clock
    input  wire logic               presetn,                  // async reset, low
    input  wire logic               psel,                     // apb select
    input  wire logic               penable,                  // apb access phase
    input  wire logic               pwrite,                   // apb direction
    input  wire logic [ADDR_W-1:0]  paddr,                    // apb byte address
    input  wire logic [DATA_W-1:0]  pwdata,                   // apb write data
    input  wire logic [STRB_W-1:0]  pstrb,                    // apb byte strobes
    output logic      [DATA_W-1:0]  prdata,                   // apb read data
    output logic                    pready,                   // apb ready
    output logic                    pslverr,                  // unmapped address
    input  wire logic               tx_early_evt,             // packet moved to tx fifo
    input  wire logic               rx_early_evt,             // first rx descriptor full
    input  wire logic               xcvr_evt,                 // transceiver event
    input  wire logic               tx_defer_evt,             // transmit deferred
    input  wire logic               pause_evt,                // pause frame received
    input  wire logic [ALIAS_W-1:0] primary_evt,              // primary status events
    input  wire logic [STATE_W-1:0] transmit_engine_state,    // tx engine state
    input  wire logic [STATE_W-1:0] receive_engine_state,     // rx engine state
    input  wire logic [STATE_W-1:0] bus_err_type,             // bus error type
    output logic                    irq,                      // interrupt request
    output logic                    primary_normal_summary,   // primary normal summary
    output logic                    primary_abnormal_summary  // primary abnormal summary
);

    // ----------------------------------------------------------------
    // flag bank
    // ----------------------------------------------------------------
    aise_flag_if fl ();

    aise_flag_bank u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (fl.bank)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic              access;
    logic              commit;
    logic              wr;
    logic              hit_pri_stat;
    logic              hit_pri_en;
    logic              hit_aux_stat;
    logic              hit_aux_en;
    logic              hit_any;
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] wbits;

    // access waits one cycle for the registered ready
    always_comb begin
        access       = psel & penable & ~pready;
        commit       = psel & penable & pready;
        wr           = commit & pwrite;
        hit_pri_stat = (paddr == PRI_STAT_ADDR);
        hit_pri_en   = (paddr == PRI_EN_ADDR);
        hit_aux_stat = (paddr == AUX_STAT_ADDR);
        hit_aux_en   = (paddr == AUX_EN_ADDR);
        hit_any      = hit_pri_stat | hit_pri_en | hit_aux_stat | hit_aux_en;
        for (int b = 0; b < STRB_W; b++) begin
            wmask[b*8 +: 8] = {8{pstrb[b]}};
        end
        wbits = pwdata & wmask;
    end

    // ----------------------------------------------------------------
    // enable register
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] en;
    logic [DATA_W-1:0] next_en;

    // the low alias bits are one store seen at two addresses
    always_comb begin
        next_en = en;
        if (wr && hit_aux_en) begin
            next_en = ((en & ~wmask) | wbits) & EN_MASK;
        end else if (wr && hit_pri_en) begin
            next_en[ALIAS_W-1:0] = (en[ALIAS_W-1:0] & ~wmask[ALIAS_W-1:0])
                                 | wbits[ALIAS_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= AUX_EN_RST;
        end else begin
            en <= next_en;
        end
    end

    // ----------------------------------------------------------------
    // set and clear requests to the flag bank
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] evt;
    logic [DATA_W-1:0] set_vec;
    logic [DATA_W-1:0] clr_vec;

    // early flags latch only while their enable is on
    always_comb begin
        evt                       = '0;
        evt[TX_EARLY_BIT]         = tx_early_evt;
        evt[RX_EARLY_BIT]         = rx_early_evt;
        evt[XCVR_BIT]             = xcvr_evt;
        evt[TX_DEFER_BIT]         = tx_defer_evt;
        evt[PAUSE_BIT]            = pause_evt;
        set_vec                   = '0;
        set_vec[TX_EARLY_BIT]     = evt[TX_EARLY_BIT] & en[TX_EARLY_BIT];
        set_vec[RX_EARLY_BIT]     = evt[RX_EARLY_BIT] & en[RX_EARLY_BIT];
        set_vec[XCVR_BIT]         = evt[XCVR_BIT];
        set_vec[TX_DEFER_BIT]     = evt[TX_DEFER_BIT];
        set_vec[PAUSE_BIT]        = evt[PAUSE_BIT];
        set_vec[ADD_NORM_BIT]     = |(evt & en & ADD_NORM_MASK);
        set_vec[ADD_ABN_BIT]      = |(evt & en & ADD_ABN_MASK);
        set_vec[ALIAS_W-1:0]      = primary_evt;
    end

    // a one written clears; zeros and reserved bits do nothing
    always_comb begin
        clr_vec = '0;
        if (wr && hit_aux_stat) begin
            clr_vec = wbits & FLAG_MASK;
        end else if (wr && hit_pri_stat) begin
            clr_vec[ALIAS_W-1:0] = wbits[ALIAS_W-1:0];
        end
    end

    assign fl.set = set_vec;
    assign fl.clr = clr_vec;

    // ----------------------------------------------------------------
    // summaries and interrupt request
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] armed;
    logic              next_pri_norm;
    logic              next_pri_abn;
    logic              next_irq;

    // summary bits follow the flags a cycle late; they hold no state
    always_comb begin
        armed         = fl.flags & en & FLAG_MASK;
        next_pri_norm = |(armed[ALIAS_W-1:0] & PRI_NORM_SRC)
                      | (en[ADD_NORM_BIT] & |(armed & ADD_NORM_MASK));
        next_pri_abn  = |(armed[ALIAS_W-1:0] & ~PRI_NORM_SRC)
                      | (en[ADD_ABN_BIT] & |(armed & ADD_ABN_MASK));
        next_irq      = |armed;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_normal_summary   <= 1'b0;
            primary_abnormal_summary <= 1'b0;
            irq                      <= 1'b0;
        end else begin
            primary_normal_summary   <= next_pri_norm;
            primary_abnormal_summary <= next_pri_abn;
            irq                      <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] aux_stat_rd;
    logic [DATA_W-1:0] pri_stat_rd;
    logic [DATA_W-1:0] rd_mux;

    // engine states are live views; they raise no interrupt
    always_comb begin
        aux_stat_rd = fl.flags & FLAG_MASK;
        aux_stat_rd[TX_STATE_LSB +: STATE_W] = transmit_engine_state;
        aux_stat_rd[RX_STATE_LSB +: STATE_W] = receive_engine_state;
        aux_stat_rd[BUS_ERR_LSB +: STATE_W]  = bus_err_type;
        pri_stat_rd                          = '0;
        pri_stat_rd[ALIAS_W-1:0]             = fl.flags[ALIAS_W-1:0];
        pri_stat_rd[PRI_NORM_BIT]            = primary_normal_summary;
        pri_stat_rd[PRI_ABN_BIT]             = primary_abnormal_summary;
        rd_mux = '0;
        if (hit_aux_stat) begin
            rd_mux = aux_stat_rd;
        end else if (hit_aux_en) begin
            rd_mux = en & EN_MASK;
        end else if (hit_pri_stat) begin
            rd_mux = pri_stat_rd;
        end else if (hit_pri_en) begin
            rd_mux[ALIAS_W-1:0] = en[ALIAS_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] next_prdata;
    logic              next_pready;
    logic              next_pslverr;

    // one wait state keeps every answer straight from a flop
    always_comb begin
        next_pready  = access;
        next_pslverr = access & ~hit_any;
        next_prdata  = prdata;
        if (access) begin
            next_prdata = (pwrite || !hit_any) ? '0 : rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : aise_top

// *** tb/aise_top_chk.sv ***
// port checker for the auxiliary interrupt status and enable block
// assumes one pclk domain with asynchronous active-low presetn
module aise_top_chk
    import aise_pkg::*;
(
    input wire logic               pclk,                    // clock
    input wire logic               presetn,                 // reset, low
    input wire logic               psel,                    // select
    input wire logic               penable,                 // access phase
    input wire logic               pwrite,                  // direction
    input wire logic [ADDR_W-1:0]  paddr,                   // address
    input wire logic [DATA_W-1:0]  prdata,                  // read data
    input wire logic               pready,                  // ready
    input wire logic               pslverr,                 // error
    input wire logic [STATE_W-1:0] transmit_engine_state,   // tx state
    input wire logic [STATE_W-1:0] receive_engine_state,    // rx state
    input wire logic               irq,                     // interrupt
    input wire logic               primary_normal_summary,  // normal sum
    input wire logic               primary_abnormal_summary // abnormal sum
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // flags and enables may only drop after a write has completed
    logic wr_done;
    assign wr_done = psel & penable & pwrite & pready;
    // bus timing and read views
    AST_READY_LAT: assert property (psel && $rose(penable) |=> pready)
        else $error("no ready one cycle after access");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_ZERO: assert property ((pslverr || (pready && pwrite)) |-> pready && prdata == 32'h0)
        else $error("error or write without ready or with data");
    AST_STATE_VIEW: assert property (pready && !pwrite && !pslverr && paddr == AUX_STAT_ADDR |->
        prdata[22:17] == $past({transmit_engine_state, receive_engine_state}) && !prdata[27])
        else $error("engine state view wrong");
    AST_EN_RSVD: assert property (pready && !pwrite && paddr == AUX_EN_ADDR |->
        (prdata & 32'h0BFE_0000) == 32'h0) else $error("reserved enable bits set");
    AST_PRI_READ: assert property (pready && !pwrite && paddr == PRI_STAT_ADDR |->
        prdata[31:17] == 15'h0) else $error("primary status upper bits set");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_done, 2))
        else $error("interrupt dropped without a write");
    AST_SUM_FALL: assert property ($fell(primary_normal_summary) |-> $past(wr_done, 2))
        else $error("normal summary dropped without a write");
    AST_SUM_IRQ: assert property (primary_normal_summary || primary_abnormal_summary |-> irq)
        else $error("summary without interrupt");
    cover property (pslverr);
    cover property ($rose(irq));
    cover property ($rose(primary_abnormal_summary));
endmodule : aise_top_chk

bind aise_top aise_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmit_engine_state(transmit_engine_state),
    .receive_engine_state(receive_engine_state), .irq(irq),
    .primary_normal_summary(primary_normal_summary),
    .primary_abnormal_summary(primary_abnormal_summary));

// *** tb/aise_top_tb.sv ***
// self-checking bench for the auxiliary interrupt register block
// assumes the design answers every apb access within a few cycles
module aise_top_tb
    import aise_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic        irq, pns, pas;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [4:0]  ev;
    logic [14:0] pev;
    logic [2:0]  tes, res, bet;
    int          n_errors, total_checks;
    // event vector order: tx early, rx early, transceiver, deferred, pause
    aise_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_early_evt(ev[4]), .rx_early_evt(ev[3]),
        .xcvr_evt(ev[2]), .tx_defer_evt(ev[1]), .pause_evt(ev[0]), .primary_evt(pev),
        .transmit_engine_state(tes), .receive_engine_state(res), .bus_err_type(bet),
        .irq(irq), .primary_normal_summary(pns), .primary_abnormal_summary(pas));
    // 250 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    // one apb transfer; a read compares against d, the wait is bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        last_err = pslverr;
        if (!w) chk(prdata, d);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    // one-cycle event pulse, returns once irq has had time to follow
    task automatic pulse(input logic [4:0] e, input logic [14:0] p);
        {ev, pev} <= {e, p};
        @(posedge pclk);
        {ev, pev} <= 20'h0_0000;
        repeat (2) @(posedge pclk);
    endtask : pulse
    task automatic t_regs;
        apb(1'b0, AUX_STAT_ADDR, 32'h2000_8000);
        apb(1'b0, AUX_EN_ADDR, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, last_err}, 32'h0000_0001);
        apb(1'b1, AUX_EN_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, AUX_EN_ADDR, 32'hF401_FFFF);
        apb(1'b0, PRI_EN_ADDR, 32'h0000_7FFF);
        apb(1'b1, AUX_EN_ADDR, 32'h0000_0000);
        $display("register map test done");
    endtask : t_regs
    // every engine state code, flags held at their reset values
    task automatic t_state;
        for (int i = 0; i < 8; i++) begin
            {tes, res, bet} <= {3'(i), 3'(7 - i), 3'(i)};
            @(posedge pclk);
            apb(1'b0, AUX_STAT_ADDR, {6'h08, 3'(i), 3'(i), 3'(7 - i), 17'h0_8000});
        end
        {tes, res, bet} <= 9'h000;
        $display("engine state test done");
    endtask : t_state
    task automatic t_early;
        pulse(5'h10, 15'h0000);
        apb(1'b0, AUX_STAT_ADDR, 32'h2000_8000);
        apb(1'b1, AUX_EN_ADDR, 32'hC001_0000);
        pulse(5'h10, 15'h0000);
        chk({30'h0, irq, pns}, 32'h0000_0003);
        apb(1'b0, AUX_STAT_ADDR, 32'hA001_8000);
        pulse(5'h08, 15'h0000);
        apb(1'b0, AUX_STAT_ADDR, 32'hE001_8000);
        apb(1'b1, AUX_STAT_ADDR, 32'h0000_0000);
        apb(1'b0, AUX_STAT_ADDR, 32'hE001_8000);
        apb(1'b1, AUX_STAT_ADDR, 32'hC001_0000);
        apb(1'b0, AUX_STAT_ADDR, 32'h2000_8000);
        chk({30'h0, irq, pns}, 32'h0000_0000);
        apb(1'b1, AUX_EN_ADDR, 32'h0000_0000);
        $display("early interrupt test done");
    endtask : t_early
    // abnormal sources, then a primary bit seen through both addresses
    task automatic t_abn;
        apb(1'b1, AUX_STAT_ADDR, 32'h2000_8000);
        apb(1'b0, AUX_STAT_ADDR, 32'h0000_0000);
        apb(1'b1, AUX_EN_ADDR, 32'h3400_8000);
        pulse(5'h07, 15'h0000);
        chk({30'h0, irq, pas}, 32'h0000_0003);
        apb(1'b0, AUX_STAT_ADDR, 32'h3400_8000);
        apb(1'b1, AUX_STAT_ADDR, 32'h3400_8000);
        apb(1'b1, AUX_EN_ADDR, 32'h0000_0008);
        pulse(5'h00, 15'h0008);
        chk({30'h0, irq, pas}, 32'h0000_0003);
        apb(1'b0, PRI_STAT_ADDR, 32'h0000_8008);
        apb(1'b0, AUX_STAT_ADDR, 32'h0000_0008);
        apb(1'b1, PRI_STAT_ADDR, 32'h0000_0008);
        apb(1'b0, AUX_STAT_ADDR, 32'h0000_0000);
        $display("abnormal and alias test done");
    endtask : t_abn
    // enables written through the primary address, a normal primary source, byte strobes
    task automatic t_alias;
        apb(1'b1, PRI_EN_ADDR, 32'hFFFF_C045);
        apb(1'b0, AUX_EN_ADDR, 32'h0000_4045);
        pulse(5'h00, 15'h0001);
        chk({30'h0, irq, pns}, 32'h0000_0003);
        apb(1'b0, PRI_STAT_ADDR, 32'h0001_0001);
        apb(1'b1, AUX_STAT_ADDR, 32'h0000_0001);
        apb(1'b0, PRI_STAT_ADDR, 32'h0000_0000);
        pstrb <= 4'h2;
        apb(1'b1, AUX_EN_ADDR, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        apb(1'b0, AUX_EN_ADDR, 32'h0000_FF45);
        apb(1'b1, AUX_EN_ADDR, 32'h0000_0000);
        $display("alias and strobe test done");
    endtask : t_alias
    // reset, then the scenarios in turn
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ev, pev, tes, res, bet} = '0;
        pstrb        = 4'hF;
        n_errors     = 0;
        total_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_state();
        t_early();
        t_abn();
        t_alias();
        report_and_stop();
    end
endmodule : aise_top_tb
